// ===== hv_led_defs.svh
// register offsets, field positions, reset values and timing counts of the hv led control block
// assumes a 125 MHz core clock and byte addresses on an 8-bit apb address
`ifndef HV_LED_DEFS_SVH
`define HV_LED_DEFS_SVH

`define OFF_SINK_BANK 8'h00
`define OFF_FB_ENABLE 8'h04
`define OFF_BOOST_CTRL 8'h08
`define OFF_AUTO_THR 8'h0c
`define OFF_A_LSB 8'h10
`define OFF_A_MSB 8'h14
`define OFF_B_LSB 8'h18
`define OFF_B_MSB 8'h1c
`define OFF_A_FULLSCALE 8'h20
`define OFF_B_FULLSCALE 8'h24
`define OFF_BANK_ENABLE 8'h28
`define OFF_RAMP_TIME 8'h2c
`define OFF_PWM_CFG 8'h30
`define OFF_LEVEL 8'h34
`define OFF_STATUS 8'h38

`define BC_FREQ_BIT 0
`define BC_AUTO_BIT 3
`define PWM_EN_A_BIT 0
`define PWM_EN_B_BIT 1
`define PWM_POL_BIT 2
`define PWM_ZD_BIT 3

`define RST_SINK_BANK 3'h0
`define RST_FB_ENABLE 3'h7
`define RST_BOOST_CTRL 4'h0
`define RST_AUTO_THR 8'h6c
`define RST_FULLSCALE 5'h13
`define RST_RAMP_TIME 8'h00
`define RST_PWM_CFG 4'h0

`define CLK_MHZ 125
`define T_PWM_MIN_NS 750
`define T_PWM_MIN_CYC ((`T_PWM_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== hv_led_pkg.sv
// types shared by the hv led control block and its ramp stepper
// assumes nothing of its surroundings
package hv_led_pkg;
    typedef logic [10:0] code_t;
    typedef enum logic [2:0] {
        RAMP_HOLD = 3'b001,
        RAMP_UP = 3'b010,
        RAMP_DOWN = 3'b100
    } ramp_dir_e;
endpackage : hv_led_pkg

// ===== ramp_stepper.sv
// ramp stepper: walks an 11-bit level one code at a time toward a target
// assumes target changes only on commit; time codes pick 2**code cycles per step
`timescale 1ns/100ps
module ramp_stepper
    import hv_led_pkg::*;
(
    // clocking
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic ce,
    // control
    input wire code_t target,
    input wire logic [3:0] up_time_code,
    input wire logic [3:0] down_time_code,
    // result
    output code_t level,
    output logic moving
);
    ramp_dir_e dir;
    logic [15:0] tick;
    logic [15:0] limit;

    always_comb begin
        limit = (dir == RAMP_DOWN) ? ((16'h0001 << down_time_code) - 16'h0001)
                                   : ((16'h0001 << up_time_code) - 16'h0001);
    end

    // the full 11-bit walk is what gives fine steps when software only writes the upper byte
    always_ff @(posedge core_clk) begin
        if (!rst_n || clear) begin
            dir <= RAMP_HOLD;
            level <= '0;
            tick <= '0;
        end else if (ce) begin
            unique case (dir)
                RAMP_HOLD: begin
                    tick <= '0;
                    if (target > level) begin
                        dir <= RAMP_UP;
                    end else if (target < level) begin
                        dir <= RAMP_DOWN;
                    end
                end
                RAMP_UP, RAMP_DOWN: begin
                    if (target == level) begin
                        dir <= RAMP_HOLD;
                    end else if ((dir == RAMP_UP) != (target > level)) begin
                        dir <= RAMP_HOLD;
                    end else if (tick >= limit) begin
                        tick <= '0;
                        level <= (dir == RAMP_UP) ? level + 11'h001 : level - 11'h001;
                    end else begin
                        tick <= tick + 16'h0001;
                    end
                end
            endcase
        end
    end

    assign moving = (dir != RAMP_HOLD);
endmodule : ramp_stepper

// ===== hv_led_ctrl.sv
// hv led control: apb registers, bank mapping, brightness commit, ramps, pwm duty and boost frequency
// assumes pins arrive unsynchronised; apb master on core_clk; ce low freezes everything
`timescale 1ns/100ps
`include "hv_led_defs.svh"
module hv_led_ctrl
    import hv_led_pkg::*;
#(
    parameter int PWM_WIN_BITS = 16
) (
    // clocking
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // pins
    input wire logic hardware_enable_pin,
    input wire logic pwm_pin,
    input wire logic [2:0] short_pin,
    // boost and sinks
    output logic device_active,
    output logic boost_freq_1mhz,
    output logic [2:0] feedback_enable,
    output logic [2:0] short_fault,
    output code_t hv_string_sink_1_code,
    output code_t hv_string_sink_2_code,
    output code_t hv_string_sink_3_code,
    output logic [4:0] hv_string_sink_1_fullscale,
    output logic [4:0] hv_string_sink_2_fullscale,
    output logic [4:0] hv_string_sink_3_fullscale
);
    // pin synchronisers: three stages, a change counts once stages two and three agree
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] pins_ok;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pins_ok <= '0;
        end else if (ce) begin
            sync1 <= {hardware_enable_pin, pwm_pin, short_pin};
            sync2 <= sync1;
            sync3 <= sync2;
            // take stage three only when two and three agree, otherwise keep the last agreed value
            pins_ok <= (sync3 & ~(sync2 ^ sync3)) | (pins_ok & (sync2 ^ sync3));
        end
    end

    logic hardware_enable_pin_ok;
    logic pwm_ok;
    logic [2:0] short_ok;
    logic clear;
    assign hardware_enable_pin_ok = pins_ok[4];
    assign pwm_ok = pins_ok[3];
    assign short_ok = pins_ok[2:0];
    assign clear = !hardware_enable_pin_ok;

    // registers
    logic [2:0] sink_bank;
    logic [2:0] fb_en;
    logic [3:0] boost_ctrl;
    logic [7:0] auto_thr;
    logic [2:0] a_lsb;
    logic [2:0] b_lsb;
    code_t a_target;
    code_t b_target;
    logic [4:0] a_fullscale;
    logic [4:0] b_fullscale;
    logic [1:0] bank_en;
    logic [7:0] ramp_time;
    logic [3:0] pwm_cfg;

    logic xfer;
    logic wr;
    assign xfer = psel && penable && pready;
    assign wr = xfer && pwrite;

    always_ff @(posedge core_clk) begin
        if (!rst_n || clear) begin
            sink_bank <= `RST_SINK_BANK;
            fb_en <= `RST_FB_ENABLE;
            boost_ctrl <= `RST_BOOST_CTRL;
            auto_thr <= `RST_AUTO_THR;
            a_lsb <= '0;
            b_lsb <= '0;
            a_target <= '0;
            b_target <= '0;
            a_fullscale <= `RST_FULLSCALE;
            b_fullscale <= `RST_FULLSCALE;
            bank_en <= '0;
            ramp_time <= `RST_RAMP_TIME;
            pwm_cfg <= `RST_PWM_CFG;
        end else if (ce && wr) begin
            unique case (paddr)
                `OFF_SINK_BANK: sink_bank <= pwdata[2:0];
                `OFF_FB_ENABLE: fb_en <= pwdata[2:0];
                `OFF_BOOST_CTRL: boost_ctrl <= pwdata[3:0];
                `OFF_AUTO_THR: auto_thr <= pwdata[7:0];
                `OFF_A_LSB: a_lsb <= pwdata[2:0];
                `OFF_A_MSB: a_target <= {pwdata[7:0], a_lsb};
                `OFF_B_LSB: b_lsb <= pwdata[2:0];
                `OFF_B_MSB: b_target <= {pwdata[7:0], b_lsb};
                `OFF_A_FULLSCALE: a_fullscale <= pwdata[4:0];
                `OFF_B_FULLSCALE: b_fullscale <= pwdata[4:0];
                `OFF_BANK_ENABLE: bank_en <= pwdata[1:0];
                `OFF_RAMP_TIME: ramp_time <= pwdata[7:0];
                `OFF_PWM_CFG: pwm_cfg <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // ramps: startup code for rising, shutdown code for falling, both banks share them
    code_t a_level;
    code_t b_level;
    logic a_moving;
    logic b_moving;

    ramp_stepper ramp_a (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(clear),
        .ce(ce),
        .target(bank_en[0] ? a_target : 11'h000),
        .up_time_code(ramp_time[3:0]),
        .down_time_code(ramp_time[7:4]),
        .level(a_level),
        .moving(a_moving)
    );

    ramp_stepper ramp_b (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(clear),
        .ce(ce),
        .target(bank_en[1] ? b_target : 11'h000),
        .up_time_code(ramp_time[3:0]),
        .down_time_code(ramp_time[7:4]),
        .level(b_level),
        .moving(b_moving)
    );

    // pwm duty measure over a window of 2**PWM_WIN_BITS cycles; the default 524 us window fits the slowest source
    logic [PWM_WIN_BITS-1:0] win_cnt;
    logic [PWM_WIN_BITS:0] act_cnt;
    logic [7:0] pulse_len;
    logic pulse_seen;
    logic [8:0] duty;
    logic pwm_zero;
    logic pwm_active;
    logic pulse_long;

    assign pwm_active = pwm_ok ^ pwm_cfg[`PWM_POL_BIT];
    assign pulse_long = (pulse_len >= 8'(`T_PWM_MIN_CYC));

    always_ff @(posedge core_clk) begin
        if (!rst_n || clear) begin
            win_cnt <= '0;
            act_cnt <= '0;
            pulse_len <= '0;
            pulse_seen <= 1'b0;
            duty <= 9'h100;
            pwm_zero <= 1'b0;
        end else if (ce) begin
            win_cnt <= win_cnt + 1'b1;
            if (pwm_active) begin
                pulse_len <= pulse_long ? pulse_len : pulse_len + 8'h01;
            end else begin
                pulse_len <= '0;
            end
            if (&win_cnt) begin
                act_cnt <= '0;
                pulse_seen <= 1'b0;
                // near-zero: a window with no pulse longer than the minimum reads as no light
                if (pwm_cfg[`PWM_ZD_BIT] && !pulse_seen && !pulse_long) begin
                    duty <= 9'h000;
                    pwm_zero <= 1'b1;
                end else begin
                    duty <= 9'(act_cnt >> (PWM_WIN_BITS - 8));
                    pwm_zero <= 1'b0;
                end
            end else begin
                act_cnt <= act_cnt + (PWM_WIN_BITS + 1)'(pwm_active);
                pulse_seen <= pulse_seen || pulse_long;
            end
        end
    end

    // code times duty, where duty 256 means full scale
    function automatic code_t scale(input code_t code, input logic [8:0] d, input logic en);
        logic [19:0] prod;
        prod = 20'(code) * 20'(d);
        scale = en ? prod[18:8] : code;
    endfunction : scale

    code_t a_eff;
    code_t b_eff;
    assign a_eff = scale(a_level, duty, pwm_cfg[`PWM_EN_A_BIT]);
    assign b_eff = scale(b_level, duty, pwm_cfg[`PWM_EN_B_BIT]);

    // sink outputs: each string follows the bank chosen by its mapping bit
    always_ff @(posedge core_clk) begin
        if (!rst_n || clear) begin
            hv_string_sink_1_code <= '0;
            hv_string_sink_2_code <= '0;
            hv_string_sink_3_code <= '0;
            hv_string_sink_1_fullscale <= `RST_FULLSCALE;
            hv_string_sink_2_fullscale <= `RST_FULLSCALE;
            hv_string_sink_3_fullscale <= `RST_FULLSCALE;
        end else if (ce) begin
            hv_string_sink_1_code <= sink_bank[0] ? b_eff : a_eff;
            hv_string_sink_2_code <= sink_bank[1] ? b_eff : a_eff;
            hv_string_sink_3_code <= sink_bank[2] ? b_eff : a_eff;
            hv_string_sink_1_fullscale <= sink_bank[0] ? b_fullscale : a_fullscale;
            hv_string_sink_2_fullscale <= sink_bank[1] ? b_fullscale : a_fullscale;
            hv_string_sink_3_fullscale <= sink_bank[2] ? b_fullscale : a_fullscale;
        end
    end

    // boost frequency: auto mode compares the brighter enabled bank with the threshold
    logic [7:0] top_msb;
    always_comb begin
        top_msb = 8'h00;
        if (bank_en[0] && a_level[10:3] > top_msb) begin
            top_msb = a_level[10:3];
        end
        if (bank_en[1] && b_level[10:3] > top_msb) begin
            top_msb = b_level[10:3];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || clear) begin
            boost_freq_1mhz <= 1'b0;
            feedback_enable <= `RST_FB_ENABLE;
            short_fault <= '0;
            device_active <= 1'b0;
        end else if (ce) begin
            if (boost_ctrl[`BC_AUTO_BIT]) begin
                boost_freq_1mhz <= (top_msb > auto_thr);
            end else begin
                boost_freq_1mhz <= boost_ctrl[`BC_FREQ_BIT];
            end
            feedback_enable <= fb_en;
            short_fault <= short_ok & fb_en;
            device_active <= 1'b1;
        end
    end

    // apb: one wait state, read data and error registered with pready
    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a <= `OFF_STATUS) && (a[1:0] == 2'b00);
    endfunction : known_addr

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !known_addr(paddr);
            prdata <= '0;
            if (psel && penable && !pready && !pwrite) begin
                unique case (paddr)
                    `OFF_SINK_BANK: prdata <= {29'h0, sink_bank};
                    `OFF_FB_ENABLE: prdata <= {29'h0, fb_en};
                    `OFF_BOOST_CTRL: prdata <= {28'h0, boost_ctrl};
                    `OFF_AUTO_THR: prdata <= {24'h0, auto_thr};
                    `OFF_A_LSB: prdata <= {29'h0, a_lsb};
                    `OFF_A_MSB: prdata <= {24'h0, a_target[10:3]};
                    `OFF_B_LSB: prdata <= {29'h0, b_lsb};
                    `OFF_B_MSB: prdata <= {24'h0, b_target[10:3]};
                    `OFF_A_FULLSCALE: prdata <= {27'h0, a_fullscale};
                    `OFF_B_FULLSCALE: prdata <= {27'h0, b_fullscale};
                    `OFF_BANK_ENABLE: prdata <= {30'h0, bank_en};
                    `OFF_RAMP_TIME: prdata <= {24'h0, ramp_time};
                    `OFF_PWM_CFG: prdata <= {28'h0, pwm_cfg};
                    `OFF_LEVEL: prdata <= {5'h0, b_level, 5'h0, a_level};
                    `OFF_STATUS: prdata <= {15'h0, duty, 1'b0, short_ok & fb_en,
                                            b_moving, a_moving, pwm_zero, boost_freq_1mhz};
                    default: prdata <= '0;
                endcase
            end
        end
    end
endmodule : hv_led_ctrl

// ===== hv_led_ctrl_chk.sv
// port assertions for hv_led_ctrl, attached by bind
// assumes ce held high, so every apb answer comes in the second access cycle
`timescale 1ns/100ps
module hv_led_ctrl_chk
    import hv_led_pkg::*;
(
    // clocking
    input wire logic core_clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and outputs
    input wire logic [2:0] short_pin,
    input wire logic device_active,
    input wire logic boost_freq_1mhz,
    input wire logic [2:0] feedback_enable,
    input wire logic [2:0] short_fault,
    input wire code_t hv_string_sink_1_code,
    input wire logic [4:0] hv_string_sink_1_fullscale
);
    logic wr_done;
    logic pwm_on;
    logic [8:0] quiet;
    assign wr_done = psel && penable && pready && pwrite && device_active;
    always_ff @(posedge core_clk) begin
        if (!rst_n || !device_active)
            pwm_on <= 1'b0;
        else if (wr_done && paddr == 8'h30)
            pwm_on <= |pwdata[1:0];
    end
    // duty scaling may jump the code, so steps are judged only after a long spell with pwm off
    always_ff @(posedge core_clk) begin
        if (!rst_n || !device_active || pwm_on)
            quiet <= 9'h0;
        else if (quiet != 9'h1ff)
            quiet <= quiet + 9'h1;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    property p_apb_wait;
        s_setup |=> s_answer;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer out of place");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_refuse;
        psel && penable && pready && (paddr > 8'h38 || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
    property p_reset_vals;
        $rose(rst_n) |-> feedback_enable == 3'h7 && hv_string_sink_1_fullscale == 5'h13;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong value out of reset");
    property p_freq_fixed;
        wr_done && paddr == 8'h08 && !pwdata[3] |-> ##3 boost_freq_1mhz == $past(pwdata[0], 3);
    endproperty
    a_freq_fixed: assert property (p_freq_fixed) else $error("frequency select not followed");
    property p_fb_write;
        wr_done && paddr == 8'h04 |-> ##2 feedback_enable == $past(pwdata[2:0], 2);
    endproperty
    a_fb_write: assert property (p_fb_write) else $error("feedback enables not written");
    property p_short_gate;
        (device_active && $stable(short_pin) && $stable(feedback_enable)) [*6] |->
            short_fault == (short_pin & feedback_enable);
    endproperty
    a_short_gate: assert property (p_short_gate) else $error("short fault not gated");
    property p_step;
        quiet == 9'h1ff && device_active |->
            hv_string_sink_1_code - $past(hv_string_sink_1_code) inside {11'h0, 11'h1, 11'h7ff};
    endproperty
    a_step: assert property (p_step) else $error("ramp jumped more than one code");
endmodule : hv_led_ctrl_chk

// ===== pwm_source.sv
// pwm brightness source model: fixed-period pulse train on the pwm pin
// assumes the bench changes the high time only between measurements
`timescale 1ns/100ps
module pwm_source (
    // clocking
    input wire logic core_clk,
    input wire logic rst_n,
    // shape
    input wire logic [7:0] period,
    input wire logic [7:0] high_cyc,
    // pin
    output logic pwm_pin
);
    logic [7:0] phase;
    // period stands for the usable band, scaled to the short duty window
    always_ff @(posedge core_clk) begin
        if (!rst_n || phase >= period - 8'h1)
            phase <= 8'h0;
        else
            phase <= phase + 8'h1;
    end
    always_ff @(posedge core_clk) begin
        pwm_pin <= rst_n && (phase < high_cyc);
    end
endmodule : pwm_source

// ===== hv_led_brightness_control_bench.sv
// self-checking bench for the hv led control block over apb
// assumes hv_led_ctrl, its checker and the pwm source model are compiled first
`timescale 1ns/100ps
module hv_led_brightness_control_bench;
    import hv_led_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n, ce, psel, penable, pwrite, pready, pslverr, err, hardware_enable_pin, pwm_pin, freq, act;
    logic [7:0] paddr, period, high_cyc;
    logic [31:0] pwdata, prdata, rdata, c1, c2, c3, c_hold;
    logic [2:0] short_pin, fb, sf;
    code_t code1, code2, code3;
    logic [4:0] fs1, fs2, fs3;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] pw_high [5] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h40};
    logic [31:0] pw_cfg [5] = '{32'h1, 32'h5, 32'h9, 32'h0, 32'h1};
    logic [31:0] pw_exp [5] = '{32'h22, 32'h66, 32'h0, 32'h88, 32'h88};
    assign c1 = 32'(code1);
    assign c2 = 32'(code2);
    assign c3 = 32'(code3);
    always #4 core_clk = ~core_clk;
    hv_led_ctrl #(.PWM_WIN_BITS(8)) hv_led_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .hardware_enable_pin(hardware_enable_pin), .pwm_pin(pwm_pin), .short_pin(short_pin),
        .device_active(act), .boost_freq_1mhz(freq), .feedback_enable(fb), .short_fault(sf),
        .hv_string_sink_1_code(code1), .hv_string_sink_2_code(code2), .hv_string_sink_3_code(code3),
        .hv_string_sink_1_fullscale(fs1), .hv_string_sink_2_fullscale(fs2), .hv_string_sink_3_fullscale(fs3));
    pwm_source pwm_source_i (.core_clk(core_clk), .rst_n(rst_n), .period(period), .high_cyc(high_cyc),
        .pwm_pin(pwm_pin));
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask : ticks
    // an idle cycle first, so a strobe is never lowered and raised in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            mismatches++;
            $display("BAD pready expected 1 seen %b", pready);
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("reg", e, rdata);
    endtask : rd
    initial begin
        #160000;
        mismatches++;
        $display("BAD watchdog expected end seen hang");
        test_done;
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        hardware_enable_pin = 1'b1;
        short_pin = 3'h0;
        period = 8'h40;
        high_cyc = 8'h0;
        ticks(10);
        rst_n <= 1'b1;
        ticks(6);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h7);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h6c);
        rd(8'h20, 32'h13);
        rd(8'h30, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk("err", 32'h1, 32'(err));
        chk("rdata", 32'h0, rdata);
        apb(1'b1, 8'h06, 32'h1);
        chk("err", 32'h1, 32'(err));
        rd(8'h04, 32'h7);
        $display("test registers done");
        wr(8'h28, 32'h1);
        wr(8'h10, 32'h5);
        ticks(20);
        chk("lsb only", 32'h0, c1);
        wr(8'h14, 32'h20);
        ticks(280);
        chk("commit", 32'h105, c1);
        wr(8'h10, 32'h0);
        ticks(20);
        chk("lsb held", 32'h105, c1);
        wr(8'h14, 32'h10);
        ticks(200);
        chk("8-bit", 32'h80, c1);
        wr(8'h10, 32'h3);
        wr(8'h14, 32'h10);
        ticks(20);
        chk("11-bit", 32'h83, c1);
        $display("test brightness done");
        wr(8'h2c, 32'h21);
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h11);
        ticks(6);
        chk("rising", 32'h1, 32'(c1 > 32'h83 && c1 < 32'h88));
        ticks(14);
        chk("risen", 32'h88, c1);
        wr(8'h28, 32'h0);
        ticks(300);
        chk("falling", 32'h1, 32'(c1 > 32'h0 && c1 < 32'h88));
        // clock enable low must hold the ramp where it stands
        ce <= 1'b0;
        ticks(1);
        c_hold = c1;
        ticks(50);
        chk("frozen", c_hold, c1);
        ce <= 1'b1;
        ticks(300);
        chk("off", 32'h0, c1);
        wr(8'h2c, 32'h0);
        wr(8'h28, 32'h1);
        ticks(150);
        chk("on", 32'h88, c1);
        $display("test ramp done");
        wr(8'h00, 32'h2);
        wr(8'h24, 32'h0a);
        wr(8'h28, 32'h3);
        wr(8'h18, 32'h0);
        wr(8'h1c, 32'h40);
        ticks(530);
        chk("sink2", 32'h200, c2);
        chk("fs2", 32'h0a, 32'(fs2));
        chk("fs1", 32'h13, 32'(fs1));
        chk("sink3", 32'h88, c3);
        chk("fs3", 32'h13, 32'(fs3));
        rd(8'h34, 32'h02000088);
        wr(8'h08, 32'h1);
        ticks(4);
        chk("freq", 32'h1, 32'(freq));
        rd(8'h38, 32'h1);
        wr(8'h0c, 32'h40);
        wr(8'h08, 32'h9);
        ticks(4);
        chk("auto eq", 32'h0, 32'(freq));
        wr(8'h0c, 32'h3f);
        ticks(4);
        chk("auto gt", 32'h1, 32'(freq));
        wr(8'h08, 32'h0);
        ticks(4);
        chk("fixed", 32'h0, 32'(freq));
        $display("test mapping done");
        for (int i = 0; i < 5; i++) begin
            high_cyc <= pw_high[i];
            wr(8'h30, pw_cfg[i]);
            ticks(1000);
            chk("pwm", pw_exp[i], (c1 + 32'h1 == pw_exp[i] || c1 == pw_exp[i] + 32'h1) ? pw_exp[i] : c1);
            chk("bank b", 32'h200, c2);
        end
        wr(8'h30, 32'h0);
        $display("test pwm done");
        wr(8'h04, 32'h5);
        ticks(3);
        chk("fb", 32'h5, 32'(fb));
        short_pin <= 3'h7;
        ticks(8);
        chk("short", 32'h5, 32'(sf));
        short_pin <= 3'h0;
        wr(8'h08, 32'h1);
        wr(8'h28, 32'h0);
        ticks(600);
        hardware_enable_pin <= 1'b0;
        ticks(10);
        chk("active off", 32'h0, 32'(act));
        hardware_enable_pin <= 1'b1;
        ticks(10);
        chk("active on", 32'h1, 32'(act));
        chk("freq", 32'h0, 32'(freq));
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h7);
        $display("test enable pin done");
        test_done;
    end
endmodule : hv_led_brightness_control_bench
bind hv_led_ctrl hv_led_ctrl_chk hv_led_ctrl_chk_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .short_pin(short_pin), .device_active(device_active), .boost_freq_1mhz(boost_freq_1mhz),
    .feedback_enable(feedback_enable), .short_fault(short_fault), .hv_string_sink_1_code(hv_string_sink_1_code),
    .hv_string_sink_1_fullscale(hv_string_sink_1_fullscale));
